// *** hw/toc_pkg.sv ***
/*
 Constants for the output compare channel: register map, field positions,
 reset values and mode encodings.
 Assumes a 32-bit APB slave with one aligned word per register.
*/
package toc_pkg;

  // Register byte addresses
  localparam logic [7:0] TOC_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] TOC_ADDR_PRI    = 8'h04;
  localparam logic [7:0] TOC_ADDR_SEC    = 8'h08;
  localparam logic [7:0] TOC_ADDR_STATUS = 8'h0C;

  // Control field positions
  localparam int TOC_BIT_IDLE_HALT = 13;
  localparam int TOC_BIT_FAULT     = 4;
  localparam int TOC_BIT_TBSEL     = 3;
  localparam int TOC_MODE_LSB      = 0;

  // Writable control bits: 13, 3, 2..0
  localparam logic [15:0] TOC_CTRL_WMASK = 16'h200F;
  localparam logic [15:0] TOC_CTRL_RST   = 16'h0000;
  localparam logic [15:0] TOC_CMP_RST    = 16'h0000;

  typedef enum logic [2:0] {
    TOC_M_OFF    = 3'h0,
    TOC_M_HIGH1  = 3'h1,
    TOC_M_LOW1   = 3'h2,
    TOC_M_TOGGLE = 3'h3,
    TOC_M_PULSE1 = 3'h4,
    TOC_M_PULSEN = 3'h5,
    TOC_M_PWM    = 3'h6,
    TOC_M_PWMF   = 3'h7
  } toc_mode_e;

endpackage

// *** hw/toc_edge.sv ***
/*
 Edge detector: one-cycle pulses on rising and falling edges of a level.
 Assumes the input is synchronous to the clock.
*/
module toc_edge (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Level in, edges out
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  logic prev_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= level;
    end
  end

  assign rise = level & ~prev_ff;
  assign fall = ~level & prev_ff;
endmodule

// *** hw/toc_channel.sv ***
/*
 Output compare channel with APB register access. Compares one of two
 shared timer counts with two compare values and drives the output pin.
 Assumes timer counts and their period-rollover pulses arrive synchronous
 to pclk; the fault input is active low and synchronous.
*/
module toc_channel
  import toc_pkg::*;
(
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Shared timers
  input  wire logic [15:0] timer_a_count,
  input  wire logic        timer_a_rollover,
  input  wire logic [15:0] timer_b_count,
  input  wire logic        timer_b_rollover,
  // System
  input  wire logic        cpu_idle,
  input  wire logic        fault_input_a_n,
  // Pin and events
  output logic             compare_output_pin,
  output logic             compare_output_en,
  output logic             compare_irq
);
  import toc_pkg::*;

  logic [15:0] ctrl_ff;
  logic [15:0] pri_ff;
  logic [15:0] sec_ff;
  logic [15:0] duty_ff;
  logic        fault_status_ff;
  logic        pin_ff;
  logic        armed_ff;
  logic        irq_ff;
  logic [31:0] prdata_ff;
  logic        mode_wr;
  logic [2:0]  compare_mode;
  logic        run;
  logic [15:0] count;
  logic        rollover;
  logic        match_pri;
  logic        match_sec;
  logic        pin_rise;
  logic        pin_fall;
  logic        fault_fall;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        init_ff;
  logic        ev_rise;
  logic        ev_fall;

  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign addr_ok = (paddr == TOC_ADDR_CTRL) | (paddr == TOC_ADDR_PRI) |
                   (paddr == TOC_ADDR_SEC)  | (paddr == TOC_ADDR_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata  = prdata_ff;
  assign mode_wr = wr_en & (paddr == TOC_ADDR_CTRL);

  assign compare_mode = ctrl_ff[TOC_MODE_LSB +: 3];
  assign run      = ~(ctrl_ff[TOC_BIT_IDLE_HALT] & cpu_idle);
  assign count    = ctrl_ff[TOC_BIT_TBSEL] ? timer_b_count : timer_a_count;
  assign rollover = ctrl_ff[TOC_BIT_TBSEL] ? timer_b_rollover : timer_a_rollover;
  assign match_pri = run & (count == pri_ff);
  assign match_sec = run & (count == sec_ff);

  // Control, write masking of unimplemented bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= TOC_CTRL_RST;
    end else if (mode_wr) begin
      ctrl_ff <= pwdata[15:0] & TOC_CTRL_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_ff <= TOC_CMP_RST;
      sec_ff <= TOC_CMP_RST;
    end else if (wr_en) begin
      if (paddr == TOC_ADDR_PRI) begin
        pri_ff <= pwdata[15:0];
      end
      if (paddr == TOC_ADDR_SEC) begin
        sec_ff <= pwdata[15:0];
      end
    end
  end

  // Read data registered in setup so it is stable in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        TOC_ADDR_CTRL: prdata_ff <= {16'h0000, ctrl_ff[15:5], fault_status_ff,
                                     ctrl_ff[3:0]};
        TOC_ADDR_PRI:  prdata_ff <= {16'h0000, pri_ff};
        TOC_ADDR_SEC:  prdata_ff <= {16'h0000, sec_ff};
        TOC_ADDR_STATUS: prdata_ff <= {29'h0000_0000, armed_ff, compare_output_en, pin_ff};
        default:       prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Duty buffer reloads at period boundaries and on control writes to avoid glitched cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_ff <= TOC_CMP_RST;
    end else if (mode_wr || (run && rollover)) begin
      duty_ff <= sec_ff;
    end
  end

  toc_edge u_fault_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (fault_input_a_n),
    .rise    (),
    .fall    (fault_fall)
  );

  // Fault latch: a mode rewrite clears it only once the fault is gone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_status_ff <= 1'b0;
    end else if (compare_mode == TOC_M_PWMF && !fault_input_a_n && run) begin
      fault_status_ff <= 1'b1;
    end else if (mode_wr && fault_input_a_n) begin
      fault_status_ff <= 1'b0;
    end
  end

  // Pin sequencer; armed_ff marks a one-shot still waiting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ff   <= 1'b0;
      armed_ff <= 1'b0;
    end else if (mode_wr) begin
      armed_ff <= 1'b1;
      case (pwdata[2:0])
        TOC_M_OFF:    pin_ff <= 1'b0;
        TOC_M_HIGH1:  pin_ff <= 1'b0;
        TOC_M_LOW1:   pin_ff <= 1'b1;
        TOC_M_TOGGLE: pin_ff <= pin_ff;
        TOC_M_PULSE1: pin_ff <= 1'b0;
        TOC_M_PULSEN: pin_ff <= 1'b0;
        TOC_M_PWM:    pin_ff <= (pri_ff != 16'h0000);
        TOC_M_PWMF:   pin_ff <= (pri_ff != 16'h0000) & fault_input_a_n;
        default:      pin_ff <= 1'b0;
      endcase
    end else if (run) begin
      case (compare_mode)
        TOC_M_HIGH1: begin
          if (armed_ff && match_pri) begin
            pin_ff   <= 1'b1;
            armed_ff <= 1'b0;
          end
        end
        TOC_M_LOW1: begin
          if (armed_ff && match_pri) begin
            pin_ff   <= 1'b0;
            armed_ff <= 1'b0;
          end
        end
        TOC_M_TOGGLE: begin
          if (match_pri) begin
            pin_ff <= ~pin_ff;
          end
        end
        TOC_M_PULSE1: begin
          if (armed_ff && match_pri) begin
            pin_ff <= 1'b1;
          end else if (armed_ff && pin_ff && match_sec) begin
            pin_ff   <= 1'b0;
            armed_ff <= 1'b0;
          end
        end
        TOC_M_PULSEN: begin
          if (match_pri) begin
            pin_ff <= 1'b1;
          end else if (match_sec) begin
            pin_ff <= 1'b0;
          end
        end
        TOC_M_PWM, TOC_M_PWMF: begin
          if (compare_mode == TOC_M_PWMF && (fault_status_ff || !fault_input_a_n)) begin
            pin_ff <= 1'b0;
          end else if (rollover) begin
            pin_ff <= (sec_ff != 16'h0000);
          end else if (count == duty_ff) begin
            pin_ff <= 1'b0;
          end
        end
        default: pin_ff <= 1'b0;
      endcase
    end
  end

  toc_edge u_pin_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (pin_ff),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // Pin edges made by a mode write are set-up, not events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_ff <= 1'b0;
    end else begin
      init_ff <= mode_wr;
    end
  end

  assign ev_rise = pin_rise & ~init_ff;
  assign ev_fall = pin_fall & ~init_ff;

  // Interrupt pulse one cycle after the qualifying edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      case (compare_mode)
        TOC_M_HIGH1:  irq_ff <= ev_rise;
        TOC_M_LOW1:   irq_ff <= ev_fall;
        TOC_M_TOGGLE: irq_ff <= ev_rise | ev_fall;
        TOC_M_PULSE1: irq_ff <= ev_fall;
        TOC_M_PULSEN: irq_ff <= ev_fall;
        TOC_M_PWMF:   irq_ff <= fault_fall & run;
        default:      irq_ff <= 1'b0;
      endcase
    end
  end

  assign compare_output_pin = pin_ff;
  assign compare_output_en  = (compare_mode != TOC_M_OFF);
  assign compare_irq        = irq_ff;

  AST_TBSEL: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_ff[TOC_BIT_TBSEL] |-> count == timer_b_count)
    else $error("timebase select not honoured");
  AST_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    compare_mode == TOC_M_OFF |-> !compare_output_en && !compare_irq)
    else $error("disabled channel active");
  AST_HIGH1: assert property (@(posedge pclk) disable iff (!presetn)
    compare_mode == TOC_M_HIGH1 && !mode_wr && run && armed_ff && match_pri
    |=> pin_ff ##1 compare_irq)
    else $error("one-shot high missing");
  AST_LOW1: assert property (@(posedge pclk) disable iff (!presetn)
    compare_mode == TOC_M_LOW1 && !mode_wr && run && armed_ff && match_pri
    |=> !pin_ff ##1 compare_irq)
    else $error("one-shot low missing");
  AST_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
    compare_mode == TOC_M_TOGGLE && !mode_wr && match_pri |=> pin_ff != $past(pin_ff))
    else $error("toggle missing");
  AST_PWM_NOIRQ: assert property (@(posedge pclk) disable iff (!presetn)
    compare_mode == TOC_M_PWM && $past(compare_mode) == TOC_M_PWM |-> !compare_irq)
    else $error("interrupt in plain pwm");
  AST_FAULT_SET: assert property (@(posedge pclk) disable iff (!presetn)
    compare_mode == TOC_M_PWMF && run && !fault_input_a_n |=> fault_status_ff)
    else $error("fault status not set");
  AST_FAULT_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    fault_status_ff && compare_mode == TOC_M_PWMF && !mode_wr && run |=> !pin_ff)
    else $error("pin driven during fault");
  AST_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !run && !mode_wr |=> pin_ff == $past(pin_ff))
    else $error("pin moved while halted");
  AST_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_ff & ~TOC_CTRL_WMASK) == 16'h0000)
    else $error("reserved control bit set");
  AST_PULSE1_END: assert property (@(posedge pclk) disable iff (!presetn)
    compare_mode == TOC_M_PULSE1 && !mode_wr && run && armed_ff && pin_ff && match_sec &&
    !match_pri |=> !pin_ff ##1 compare_irq)
    else $error("delayed one-shot end missing");
  AST_PULSEN_END: assert property (@(posedge pclk) disable iff (!presetn)
    compare_mode == TOC_M_PULSEN && !mode_wr && run && pin_ff && match_sec && !match_pri
    |=> !pin_ff ##1 compare_irq)
    else $error("pulse train fall missing");
  AST_FAULT_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    compare_mode == TOC_M_PWMF && run && fault_fall |=> compare_irq)
    else $error("fault interrupt missing");
  AST_PWM_RISE: assert property (@(posedge pclk) disable iff (!presetn)
    compare_mode == TOC_M_PWM && !mode_wr && run && rollover && sec_ff != 16'h0000
    |=> pin_ff)
    else $error("pwm period start missing");

  COV_HIGH1: cover property (@(posedge pclk) compare_mode == TOC_M_HIGH1 && compare_irq);
  COV_PULSEN: cover property (@(posedge pclk) compare_mode == TOC_M_PULSEN && pin_fall);
  COV_PWM: cover property (@(posedge pclk) compare_mode == TOC_M_PWM && pin_rise);
  COV_FAULT: cover property (@(posedge pclk) compare_mode == TOC_M_PWMF && compare_irq);
endmodule

// *** tb/toc_load.sv ***
/*
 Load on the compare output pad: resolves the pad level from the drive.
 Assumes a weak pull-down on the pad whenever the channel lets go.
*/
module toc_load (
  // Channel drive
  input  wire logic pin,
  input  wire logic en,
  // Pad level
  output logic      pad
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released pad must not keep the last driven value
  assign pad = en ? pin : 1'b0;
endmodule

// *** tb/timer_output_compare_test.sv ***
/*
 Self-checking bench for the output compare channel.
 Assumes a zero-wait APB slave; the shared timers are driven from here.
*/
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module timer_output_compare_test;
  timeunit 1ns;
  timeprecision 1ns;
  import toc_pkg::*;

  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        cpu_idle = 0, flt_n = 1, ra = 0, rb = 0, ep = 0, er;
  logic        pready, pslverr, pin, en, irq, pad;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] ta = 16'hFFFF, tb = 16'hFFFF, v;
  int          mismatches = 0, cmp_count = 0, irqs = 0, base, m, t;

  always #10 pclk = ~pclk;
  always @(posedge pclk) if (irq === 1'b1) irqs <= irqs + 1;

  toc_channel i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_a_count(ta), .timer_a_rollover(ra), .timer_b_count(tb),
    .timer_b_rollover(rb), .cpu_idle(cpu_idle), .fault_input_a_n(flt_n),
    .compare_output_pin(pin), .compare_output_en(en), .compare_irq(irq));
  toc_load i_load (.pin(pin), .en(en), .pad(pad));

  task automatic end_sim;
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Idle cycle at the end keeps psel from being driven twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  // One-cycle count match on a timer, then pin level and interrupt count
  task automatic hit(input logic b, input logic [15:0] c, input logic xp, input int di);
    base = irqs;
    if (b) tb <= c;
    else ta <= c;
    @(posedge pclk);
    ta <= 16'hFFFF;
    tb <= 16'hFFFF;
    repeat (3) @(posedge pclk);
    `CHK(pin, xp)
    `CHK(irqs - base, di)
  endtask

  initial begin
    v = 16'($urandom(77));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, TOC_ADDR_CTRL, 0);
    `CHK(rd, 32'h0000_0000)
    apb(1, TOC_ADDR_CTRL, 32'hFFFF_FFFF);
    apb(0, TOC_ADDR_CTRL, 0);
    `CHK(rd, 32'h0000_200F)
    apb(1, TOC_ADDR_CTRL, 0);
    `CHK({en, pad}, 2'b00)
    apb(0, 8'h10, 0);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    for (m = 1; m <= 3; m++) begin
      for (t = 0; t < 2; t++) begin
        v = 16'($urandom_range(32767, 1));
        apb(1, TOC_ADDR_PRI, {16'h0000, v});
        apb(1, TOC_ADDR_CTRL, 32'(m + 8 * t));
        if (m != 3) ep = (m == 2);
        `CHK(pin, ep)
        hit(!1'(t), v, ep, 0);
        ep = (m == 1) ? 1'b1 : (m == 2) ? 1'b0 : !ep;
        hit(1'(t), v, ep, 1);
        if (m == 3) ep = !ep;
        hit(1'(t), v, ep, int'(m == 3));
      end
    end
    apb(1, TOC_ADDR_CTRL, 32'h0000_2003);
    cpu_idle <= 1;
    hit(0, v, ep, 0);
    cpu_idle <= 0;
    ep = !ep;
    hit(0, v, ep, 1);
    for (m = 4; m <= 5; m++) begin
      apb(1, TOC_ADDR_SEC, {16'h0000, 16'(v + 16'h0010)});
      apb(1, TOC_ADDR_CTRL, 32'(m));
      `CHK(pin, 1'b0)
      hit(0, v, 1, 0);
      hit(0, v + 16'h0010, 0, 1);
      hit(0, v, m == 5, 0);
    end
    apb(1, TOC_ADDR_PRI, 0);
    apb(1, TOC_ADDR_CTRL, 32'h0000_0006);
    `CHK(pin, 1'b0)
    apb(1, TOC_ADDR_PRI, {16'h0000, v});
    apb(1, TOC_ADDR_CTRL, 32'h0000_0006);
    `CHK(pin, 1'b1)
    hit(0, v + 16'h0010, 0, 0);
    ra <= 1;
    @(posedge pclk);
    ra <= 0;
    repeat (2) @(posedge pclk);
    `CHK(pin, 1'b1)
    apb(1, TOC_ADDR_CTRL, 32'h0000_0007);
    `CHK(pin, 1'b1)
    base = irqs;
    flt_n <= 0;
    repeat (4) @(posedge pclk);
    `CHK(pin, 1'b0)
    `CHK(irqs - base, 1)
    flt_n <= 1;
    apb(0, TOC_ADDR_CTRL, 0);
    `CHK(rd, 32'h0000_0017)
    apb(1, TOC_ADDR_CTRL, 32'h0000_0007);
    apb(0, TOC_ADDR_CTRL, 0);
    `CHK(rd, 32'h0000_0007)
    apb(1, TOC_ADDR_CTRL, 32'h0000_0003);
    `CHK(pin, 1'b1)
    cpu_idle <= 1;
    hit(0, v, 0, 1);
    cpu_idle <= 0;
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    `CHK({en, pin, irq}, 3'b000)
    apb(0, TOC_ADDR_CTRL, 0);
    `CHK(rd, 32'h0000_0000)
    end_sim;
  end

  // Whole run is well under a thousand cycles
  initial begin
    #100000;
    mismatches++;
    end_sim;
  end
endmodule
